// *** otxc_pkg.sv ***
package otxc_pkg;
  // register offsets (byte addresses on the plain port)
  localparam logic [7:0] OTXC_TRIM_FIRST_OFS   = 8'h24;
  localparam logic [7:0] OTXC_STORE_3686L_OFS  = 8'h29;
  localparam logic [7:0] OTXC_STORE_3686H_OFS  = 8'h2a;
  localparam logic [7:0] OTXC_STORE_32ML_OFS   = 8'h2b;
  localparam logic [7:0] OTXC_STORE_32MH_OFS   = 8'h2c;
  localparam logic [7:0] OTXC_TRIM_SECOND_OFS  = 8'h2f;
  localparam logic [7:0] OTXC_PROTECT_OFS      = 8'h0a;
  localparam logic [7:0] OTXC_CTRL_OFS         = 8'h30;
  localparam logic [7:0] OTXC_STATUS_OFS       = 8'h31;
  // bit positions in the control and protect registers
  localparam int OTXC_CTRL_FASTEN_BIT  = 0;
  localparam int OTXC_CTRL_PINFN_BIT   = 1;
  localparam int OTXC_CTRL_STOP_BIT    = 2;
  localparam int OTXC_CTRL_SRCSEL_BIT  = 3;
  localparam int OTXC_CTRL_FBDIS_BIT   = 4;
  localparam int OTXC_PROT_UNLOCK_BIT  = 0;
  // reset values
  localparam logic [7:0] OTXC_TRIM_RESET  = 8'h80;
  localparam logic [7:0] OTXC_CTRL_RESET  = 8'h0c;
  // factory bytes, arbitrary values fixed at build time
  localparam logic [7:0] OTXC_FACT_3686L = 8'h5a;
  localparam logic [7:0] OTXC_FACT_3686H = 8'h3c;
  localparam logic [7:0] OTXC_FACT_32ML  = 8'ha5;
  localparam logic [7:0] OTXC_FACT_32MH  = 8'hc3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } otxc_bus_t;

  typedef struct packed {
    logic       fastOscOn;
    logic [7:0] trimFirst;
    logic [7:0] trimSecond;
    logic       mainOscRun;
    logic       mainClkSel;
    logic       feedbackResOn;
  } otxc_clk_t;

  typedef struct packed {
    logic [7:0] trimFirst;
    logic [7:0] trimSecond;
    logic       unlock;
    logic       fastEn;
    logic       pinFn;
    logic       stopBit;
    logic       srcSel;
    logic       fbDis;
    logic       stopMode;
    logic [1:0] stopModeSync;
    logic [7:0] rdata;
    otxc_clk_t  clk;
  } otxc_state_t;
endpackage

// *** otxc_osc_trim_and_xin_clock_ctrl.sv ***
// Behaviour
// R1: read-only factory byte for 36.864 MHz, first trim target.
// R2: second read-only factory byte for 36.864 MHz, second trim target.
// R3: read-only factory bytes for 32 MHz, first and second trim targets.
// R4: reset trim values give nominal 40 MHz fast oscillator.
// R5: copying 36.864 bytes into both trims retunes the oscillator.
// R6: copying 32 MHz bytes into both trims retunes the oscillator.
// R7: software unlocks protect bit before writing second trim.
// R8: software rewrites second trim only while fast oscillator off.
// R9: main crystal clock stays stopped through and after reset.
// R10: pin function set, then stop bit cleared starts crystal.
// R11: source select zero routes crystal clock to cpu path.
// R12: stop bit set halts crystal while internal clock selected.
// R13: external clock on output pin is not stopped by stop bit.
// R14: stop mode halts all clocks and drops feedback resistor.
// R15: feedback disable bit set removes internal feedback resistor.
// R16: software unlocks and stops fast oscillator before first trim write.
// R17: four consecutive read-only factory correction bytes.
// R18: trim writes ignored while protect bit is zero.
module otxc_osc_trim_and_xin_clock_ctrl
  import otxc_pkg::*;
(
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rstn,
  // register port
  input  wire otxc_pkg::otxc_bus_t busIn,
  output logic [7:0]               busRdata,
  // power mode pin, asynchronous
  input  wire logic                stopModeReq,
  // oscillator controls
  output otxc_pkg::otxc_clk_t      clkCtrl
);
  import otxc_pkg::*;

  otxc_state_t stateReg;
  otxc_state_t stateNext;
  logic        trimWrOk;
  logic [7:0]  ctrlRead;

  // trim writes need the unlock bit
  assign trimWrOk = stateReg.unlock; // R18

  // control register image, reserved bits read zero
  always_comb begin
    ctrlRead                       = 8'h00;
    ctrlRead[OTXC_CTRL_FASTEN_BIT] = stateReg.fastEn;
    ctrlRead[OTXC_CTRL_PINFN_BIT]  = stateReg.pinFn;
    ctrlRead[OTXC_CTRL_STOP_BIT]   = stateReg.stopBit;
    ctrlRead[OTXC_CTRL_SRCSEL_BIT] = stateReg.srcSel;
    ctrlRead[OTXC_CTRL_FBDIS_BIT]  = stateReg.fbDis;
  end

  // next-state logic
  always_comb begin
    stateNext              = stateReg;
    stateNext.stopModeSync = {stateReg.stopModeSync[0], stopModeReq};
    stateNext.stopMode     = stateReg.stopModeSync[1];
    stateNext.rdata        = 8'h00;
    // register writes
    if (busIn.wr) begin
      unique case (busIn.addr)
        OTXC_PROTECT_OFS: begin
          stateNext.unlock = busIn.wdata[OTXC_PROT_UNLOCK_BIT];
        end
        OTXC_TRIM_FIRST_OFS: begin
          // oscillator-off condition is software's duty, not enforced
          if (trimWrOk) begin
            stateNext.trimFirst = busIn.wdata; // R5 R6 R16
          end
        end
        OTXC_TRIM_SECOND_OFS: begin
          if (trimWrOk) begin
            stateNext.trimSecond = busIn.wdata; // R5 R6 R7 R8
          end
        end
        OTXC_CTRL_OFS: begin
          stateNext.fastEn  = busIn.wdata[OTXC_CTRL_FASTEN_BIT];
          stateNext.pinFn   = busIn.wdata[OTXC_CTRL_PINFN_BIT];
          stateNext.stopBit = busIn.wdata[OTXC_CTRL_STOP_BIT];
          stateNext.srcSel  = busIn.wdata[OTXC_CTRL_SRCSEL_BIT];
          stateNext.fbDis   = busIn.wdata[OTXC_CTRL_FBDIS_BIT];
        end
        default: begin
        end
      endcase
    end
    // register reads, data one cycle later; unmapped reads zero
    if (busIn.rd) begin
      unique case (busIn.addr)
        OTXC_PROTECT_OFS:     stateNext.rdata = {7'h00, stateReg.unlock};
        OTXC_TRIM_FIRST_OFS:  stateNext.rdata = stateReg.trimFirst;
        OTXC_STORE_3686L_OFS: stateNext.rdata = OTXC_FACT_3686L; // R1 R17
        OTXC_STORE_3686H_OFS: stateNext.rdata = OTXC_FACT_3686H; // R2 R17
        OTXC_STORE_32ML_OFS:  stateNext.rdata = OTXC_FACT_32ML; // R3 R17
        OTXC_STORE_32MH_OFS:  stateNext.rdata = OTXC_FACT_32MH; // R3 R17
        OTXC_TRIM_SECOND_OFS: stateNext.rdata = stateReg.trimSecond;
        OTXC_CTRL_OFS:        stateNext.rdata = ctrlRead;
        OTXC_STATUS_OFS: begin
          stateNext.rdata = {5'h00, stateReg.stopMode,
                             stateReg.clk.mainClkSel, stateReg.clk.mainOscRun};
        end
        default:              stateNext.rdata = 8'h00;
      endcase
    end
    // oscillator outputs follow registers; stop mode overrides all but the trims
    stateNext.clk.trimFirst     = stateReg.trimFirst; // R4
    stateNext.clk.trimSecond    = stateReg.trimSecond; // R4
    stateNext.clk.fastOscOn     = stateReg.fastEn & ~stateReg.stopMode; // R14
    // crystal runs only with pin function set and stop bit clear;
    // an external clock into the output pin is outside this control
    stateNext.clk.mainOscRun    = stateReg.pinFn & ~stateReg.stopBit
                                  & ~stateReg.stopMode; // R9 R10 R12 R13 R14
    stateNext.clk.mainClkSel    = ~stateReg.srcSel & stateReg.pinFn
                                  & ~stateReg.stopMode; // R11
    stateNext.clk.feedbackResOn = ~stateReg.fbDis & ~stateReg.stopMode; // R14 R15
  end

  // state register; crystal stopped from reset (stop bit set)
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stateReg                   <= '0;
      stateReg.trimFirst         <= OTXC_TRIM_RESET;
      stateReg.trimSecond        <= OTXC_TRIM_RESET;
      stateReg.stopBit           <= OTXC_CTRL_RESET[OTXC_CTRL_STOP_BIT]; // R9
      stateReg.srcSel            <= OTXC_CTRL_RESET[OTXC_CTRL_SRCSEL_BIT];
      stateReg.clk.trimFirst     <= OTXC_TRIM_RESET;
      stateReg.clk.trimSecond    <= OTXC_TRIM_RESET;
      stateReg.clk.feedbackResOn <= 1'b1;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign busRdata = stateReg.rdata;
  assign clkCtrl  = stateReg.clk;
endmodule

// *** otxc_asserts.sv ***
module otxc_asserts
  import otxc_pkg::*;
(
  // clock and reset
  input wire logic                core_clk,
  input wire logic                rstn,
  // watched ports
  input wire otxc_pkg::otxc_bus_t busIn,
  input wire logic [7:0]          busRdata,
  input wire logic                stopModeReq,
  input wire otxc_pkg::otxc_clk_t clkCtrl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       unlockReg;
  logic [7:0] wdQ;
  logic [7:0] wdQQ;
  logic       ctlWr;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // stop mode overrides outputs, so control checks skip it
  // the request reaches the outputs four samples late, hence the depth-2 look back below
  assign ctlWr = busIn.wr && busIn.addr == OTXC_CTRL_OFS;
  // shadow of the unlock bit
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) unlockReg <= 1'b0;
    else if (busIn.wr && busIn.addr == OTXC_PROTECT_OFS) unlockReg <= busIn.wdata[0];
  end
  // write data two cycles back, matching the output latency
  always_ff @(posedge core_clk) begin
    wdQ <= busIn.wdata;
    wdQQ <= wdQ;
  end
  a_store_read: assert property (busIn.rd && busIn.addr == OTXC_STORE_3686L_OFS
    |=> busRdata == OTXC_FACT_3686L) else $error("store byte read wrong");
  a_trim_second: assert property (busIn.wr && busIn.addr == OTXC_TRIM_SECOND_OFS
    && unlockReg |-> ##2 clkCtrl.trimSecond == wdQQ) else $error("second trim not taken");
  a_trim_first: assert property (busIn.wr && busIn.addr == OTXC_TRIM_FIRST_OFS
    && unlockReg |-> ##2 clkCtrl.trimFirst == wdQQ) else $error("first trim not taken");
  a_trim_locked: assert property (busIn.wr && !unlockReg && busIn.addr[7:4] == 4'h2
    |-> ##2 $stable(clkCtrl.trimFirst) && $stable(clkCtrl.trimSecond))
    else $error("locked trim write changed trim");
  a_xtal_cause: assert property ($rose(clkCtrl.mainOscRun)
    |-> ($past(busIn.wr, 2) && $past(busIn.addr, 2) == OTXC_CTRL_OFS)
    || $past(stopModeReq, 5))
    else $error("crystal started without control write");
  a_xtal_run: assert property (ctlWr && !$past(stopModeReq, 2)
    |-> ##2 clkCtrl.mainOscRun == (wdQQ[1] && !wdQQ[2]))
    else $error("crystal run state wrong");
  a_clk_route: assert property (ctlWr && !$past(stopModeReq, 2)
    |-> ##2 clkCtrl.mainClkSel == (wdQQ[1] && !wdQQ[3]))
    else $error("cpu clock routing wrong");
  a_fb_res: assert property (ctlWr && !$past(stopModeReq, 2)
    |-> ##2 clkCtrl.feedbackResOn == !wdQQ[4])
    else $error("feedback resistor state wrong");
  a_stop_mode: assert property (stopModeReq [*6] |-> !clkCtrl.mainOscRun
    && !clkCtrl.fastOscOn && !clkCtrl.feedbackResOn) else $error("stop mode left clocks on");
endmodule
bind otxc_osc_trim_and_xin_clock_ctrl otxc_asserts otxc_asserts_inst (.core_clk(core_clk),
  .rstn(rstn), .busIn(busIn), .busRdata(busRdata), .stopModeReq(stopModeReq), .clkCtrl(clkCtrl));

// *** tb_osc_trim_and_xin_clock_ctrl.sv ***
module tb_osc_trim_and_xin_clock_ctrl;
  import otxc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       stopModeReq = 1'b0;
  otxc_bus_t  busIn = '0;
  logic [7:0] busRdata;
  otxc_clk_t  clkCtrl;
  int         bad_count = 0;
  int         n_tests = 0;
  otxc_osc_trim_and_xin_clock_ctrl otxc_osc_trim_and_xin_clock_ctrl_inst (.core_clk(core_clk),
    .rstn(rstn), .busIn(busIn), .busRdata(busRdata), .stopModeReq(stopModeReq), .clkCtrl(clkCtrl));
  // 10 MHz clock
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // single-cycle strobes; each task lets an edge pass before the next request
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    busIn <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    busIn.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    busIn <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    busIn.rd <= 1'b0;
    #1;
    chk(busRdata, exp);
  endtask
  // outputs follow the register one cycle later
  task automatic tw(input logic [7:0] f, input logic [7:0] s);
    wr(OTXC_TRIM_FIRST_OFS, f);
    wr(OTXC_TRIM_SECOND_OFS, s);
    @(posedge core_clk);
    #1;
    chk(clkCtrl.trimFirst, f);
    chk(clkCtrl.trimSecond, s);
  endtask
  task automatic cw(input logic [7:0] d, input logic [2:0] e);
    wr(OTXC_CTRL_OFS, d);
    @(posedge core_clk);
    #1;
    chk(8'({clkCtrl.mainOscRun, clkCtrl.mainClkSel, clkCtrl.feedbackResOn}), 8'(e));
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // main sequence, ends with a second reset taken in stop mode
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk(8'({clkCtrl.mainOscRun, clkCtrl.feedbackResOn}), 8'h01);
    rd(OTXC_TRIM_FIRST_OFS, OTXC_TRIM_RESET);
    rd(OTXC_TRIM_SECOND_OFS, OTXC_TRIM_RESET);
    rd(OTXC_STORE_3686L_OFS, OTXC_FACT_3686L);
    rd(OTXC_STORE_3686H_OFS, OTXC_FACT_3686H);
    rd(OTXC_STORE_32ML_OFS, OTXC_FACT_32ML);
    rd(OTXC_STORE_32MH_OFS, OTXC_FACT_32MH);
    rd(8'h40, 8'h00);
    wr(OTXC_TRIM_SECOND_OFS, 8'h11);
    wr(OTXC_STORE_3686L_OFS, 8'h00);
    rd(OTXC_TRIM_SECOND_OFS, OTXC_TRIM_RESET);
    rd(OTXC_STORE_3686L_OFS, OTXC_FACT_3686L);
    wr(OTXC_PROTECT_OFS, 8'h01);
    rd(OTXC_PROTECT_OFS, 8'h01);
    tw(OTXC_FACT_3686L, OTXC_FACT_3686H);
    tw(OTXC_FACT_32ML, OTXC_FACT_32MH);
    rd(OTXC_TRIM_FIRST_OFS, OTXC_FACT_32ML);
    cw(8'h0a, 3'b101);
    cw(8'h02, 3'b111);
    cw(8'h0e, 3'b001);
    cw(8'h1a, 3'b100);
    cw(8'h0b, 3'b101);
    chk(8'(clkCtrl.fastOscOn), 8'h01);
    rd(OTXC_CTRL_OFS, 8'h0b);
    rd(OTXC_STATUS_OFS, 8'h01);
    @(posedge core_clk);
    stopModeReq <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    chk(8'({clkCtrl.mainOscRun, clkCtrl.fastOscOn, clkCtrl.feedbackResOn}), 8'h00);
    rd(OTXC_STATUS_OFS, 8'h04);
    rstn <= 1'b0;
    repeat (8) @(posedge core_clk);
    stopModeReq <= 1'b0;
    rstn <= 1'b1;
    #1;
    chk(8'({clkCtrl.mainOscRun, clkCtrl.trimFirst == OTXC_TRIM_RESET}), 8'h01);
    rd(OTXC_PROTECT_OFS, 8'h00);
    results();
  end
endmodule
